// ==== src/pcv_map.svh ====
// Constants of the program counter and vectoring block.
// Assumes nothing of its surroundings; included by the package and modules.
`ifndef PCV_MAP_SVH
`define PCV_MAP_SVH
`define PCV_PC_WIDTH 13
`define PCV_WORD_WIDTH 14
`define PCV_STACK_DEPTH 8
`define PCV_MEM_WORDS 1024
`define PCV_RESET_VECTOR 13'h0000
`define PCV_INT_VECTOR 13'h0004
`define PCV_LOW_RESET 8'h00
`define PCV_LATCH_RESET 5'h00
`define PCV_LATCH_WIDTH 5
`endif

// ==== src/pcv_pkg.sv ====
// Types shared by the program counter block.
// Assumes pcv_map.svh is on the include path.
`include "pcv_map.svh"
package pcv_pkg;
  typedef logic [`PCV_PC_WIDTH-1:0] pcv_addr_t;
  typedef enum logic [2:0] {
    PCV_OP_NEXT, PCV_OP_GOTO, PCV_OP_CALL, PCV_OP_RETURN, PCV_OP_HOLD
  } pcv_op_e;
  // One request from the core sequencer
  typedef struct packed {
    pcv_op_e op;
    logic [10:0] target;
  } pcv_ctrl_s;
  // Software access to the low byte and the upper latch
  typedef struct packed {
    logic low_we;
    logic latch_we;
    logic [7:0] wdata;
  } pcv_sw_s;
endpackage : pcv_pkg

// ==== src/pcv_stack.sv ====
// Return-address stack, nine entries (eight in the array plus the registered top), circular: overflow drops the oldest.
// Assumes push and pop never arrive together; pop data is registered.
`timescale 1ns/1ns
`default_nettype none
`include "pcv_map.svh"
module pcv_stack
  import pcv_pkg::*;
#(
  parameter int DEPTH = `PCV_STACK_DEPTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Stack access
  input wire logic push,
  input wire logic pop,
  input wire pcv_addr_t push_addr,
  output pcv_addr_t top_addr
);
  localparam int PW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << PW) != DEPTH)
      $error("pcv_stack: DEPTH must be a power of two");
  end
  pcv_addr_t mem [DEPTH];
  logic [PW-1:0] ptr_reg, ptr_next;
  pcv_addr_t top_reg, top_next;
  // Overflow wraps and overwrites the oldest entry, no error is flagged
  always_comb
  begin
    ptr_next = ptr_reg;
    top_next = top_reg;
    if (push)
    begin
      ptr_next = ptr_reg + 1'b1;
      top_next = push_addr;
    end
    else if (pop)
    begin
      ptr_next = ptr_reg - 1'b1;
      top_next = mem[ptr_reg - 1'b1];
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[ptr_reg] <= top_reg;
    if (!rst_n)
    begin
      ptr_reg <= '0;
      top_reg <= '0;
    end
    else
    begin
      ptr_reg <= ptr_next;
      top_reg <= top_next;
    end
  end
  assign top_addr = top_reg;
endmodule : pcv_stack
`default_nettype wire

// ==== src/pcv_core.sv ====
// Program counter, fetch address, vectors and return stack.
// Assumes a sequencer issuing one request per instruction cycle.
`timescale 1ns/1ns
`default_nettype none
`include "pcv_map.svh"
// Behaviour
// - Program counter is 13 bits, covering 8K words of 14 bits.
// - Small variant backs only words 0000h to 03FFh.
// - Large variant backs words 0000h to 07FFh.
// - Fetch addresses above implemented size wrap by dropping upper bits.
// - Any reset loads the counter with 0000h.
// - Taking an interrupt loads the counter with 0004h.
// - Nine-entry hardware return stack (eight array words plus the registered top) for calls and interrupts.
// - Normal instructions take one cycle; branches take two.
// - Upper five bits come from a write latch on a low-byte write; jumps take only its top two bits.
// - Low byte is software readable, writable, resets to zero.
module pcv_core
  import pcv_pkg::*;
#(
  parameter int MEM_WORDS = `PCV_MEM_WORDS,
  parameter int STACK_DEPTH = `PCV_STACK_DEPTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sequencer requests
  input wire pcv_ctrl_s ctrl,
  input wire logic int_take,
  // Software access
  input wire pcv_sw_s sw,
  // Fetch and status
  output pcv_addr_t fetch_addr,
  output logic [7:0] pc_low_byte,
  output logic [`PCV_LATCH_WIDTH-1:0] pc_upper_write_latch,
  output logic fetch_stall
);
  localparam int AW = $clog2(MEM_WORDS);
  localparam int LW = `PCV_LATCH_WIDTH;

  // Only the two built array sizes have a defined wrap point
  if (MEM_WORDS != 1024 && MEM_WORDS != 2048)
  begin : g_bad_size
    $error("pcv_core: MEM_WORDS must be 1024 or 2048");
  end
  // A jump keeps two latch bits above its 11-bit target
  if (LW < 2)
  begin : g_bad_latch
    $error("pcv_core: latch must be at least two bits wide");
  end
  // The stack pointer wraps, so its depth must be a power of two
  if (STACK_DEPTH < 2 || (1 << $clog2(STACK_DEPTH)) != STACK_DEPTH)
  begin : g_bad_depth
    $error("pcv_core: STACK_DEPTH must be a power of two");
  end

  // Drops the unbuilt upper bits; the counter itself keeps all 13
  function automatic pcv_addr_t wrap(input pcv_addr_t a);
    wrap = pcv_addr_t'(a[AW-1:0]);
  endfunction : wrap

  function automatic pcv_addr_t branch_target(
    input logic [LW-1:0] latch,
    input logic [10:0] target
  );
    branch_target = {latch[LW-1:LW-2], target};
  endfunction : branch_target

  // Every load other than the plain step costs one discarded fetch
  function automatic logic is_branch(input pcv_op_e op);
    case (op)
      PCV_OP_GOTO, PCV_OP_CALL, PCV_OP_RETURN: is_branch = 1'b1;
      default: is_branch = 1'b0;
    endcase
  endfunction : is_branch

  pcv_addr_t pc_reg, pc_next;
  pcv_addr_t fetch_reg, fetch_next;
  logic [LW-1:0] latch_reg, latch_next;
  logic flush_reg, flush_next;
  logic redirect;
  logic push, pop;
  pcv_addr_t push_addr, top_addr;
  pcv_addr_t pc_inc;

  assign pc_inc = pc_reg + 1'b1;

  // Upper latch: software writes wait here for the next load
  always_comb
  begin
    latch_next = latch_reg;
    if (sw.latch_we)
      latch_next = sw.wdata[LW-1:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      latch_reg <= `PCV_LATCH_RESET;
    end
    else
    begin
      latch_reg <= latch_next;
    end
  end

  // Counter: interrupt first, then low-byte write, then the sequencer.
  // While the stall flag stands every request is ignored, with no sign.
  always_comb
  begin
    pc_next = pc_reg;
    push = 1'b0;
    pop = 1'b0;
    push_addr = pc_inc;
    redirect = 1'b0;
    if (flush_reg)
    begin
      // Second cycle of a branch: fetched word is discarded
      pc_next = pc_reg;
    end
    else if (int_take)
    begin
      // Current address is saved; that instruction has not run yet
      push = 1'b1;
      push_addr = pc_reg;
      pc_next = `PCV_INT_VECTOR;
      redirect = 1'b1;
    end
    else if (sw.low_we)
    begin
      // Computed jump: the whole latch goes above the written byte
      pc_next = {latch_reg, sw.wdata};
      redirect = 1'b1;
    end
    else
    begin
      redirect = is_branch(ctrl.op);
      case (ctrl.op)
        PCV_OP_NEXT: pc_next = pc_inc;
        PCV_OP_GOTO: pc_next = branch_target(latch_reg, ctrl.target);
        PCV_OP_CALL:
        begin
          push = 1'b1;
          pc_next = branch_target(latch_reg, ctrl.target);
        end
        PCV_OP_RETURN:
        begin
          pop = 1'b1;
          pc_next = top_addr;
        end
        PCV_OP_HOLD: pc_next = pc_reg;
        default: pc_next = pc_inc;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pc_reg <= `PCV_RESET_VECTOR;
    end
    else
    begin
      pc_reg <= pc_next;
    end
  end

  // Stall flag: stands for the one cycle after any load other than the plain step
  always_comb
  begin
    flush_next = redirect;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flush_reg <= 1'b0;
    end
    else
    begin
      flush_reg <= flush_next;
    end
  end

  // Fetch address is registered from the next count, so it moves with it
  always_comb
  begin
    fetch_next = wrap(pc_next);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fetch_reg <= wrap(`PCV_RESET_VECTOR);
    end
    else
    begin
      fetch_reg <= fetch_next;
    end
  end

  // Overflow and underflow wrap silently, as the stack keeps no count
  pcv_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push(push),
    .pop(pop),
    .push_addr(push_addr),
    .top_addr(top_addr)
  );

  // Memory sees only the implemented bits; PC keeps all 13
  assign fetch_addr = fetch_reg;
  assign pc_low_byte = pc_reg[7:0];
  assign pc_upper_write_latch = latch_reg;
  assign fetch_stall = flush_reg;
endmodule : pcv_core
`default_nettype wire

// ==== sim/pcv_core_properties.sv ====
// Checker on the pcv_core ports.
// Assumes pcv_pkg is compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pcv_map.svh"
module pcv_core_chk
  import pcv_pkg::*;
#(parameter int MEM_WORDS = 1024)
(
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pcv_ctrl_s ctrl,
  input wire logic int_take,
  input wire pcv_sw_s sw,
  input wire pcv_addr_t fetch_addr,
  input wire logic [7:0] pc_low_byte,
  input wire logic [`PCV_LATCH_WIDTH-1:0] pc_upper_write_latch,
  input wire logic fetch_stall
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam pcv_addr_t M = pcv_addr_t'(MEM_WORDS - 1);
  logic go;
  assign go = !fetch_stall && !int_take && !sw.low_we;
  chk_reset_clear: assert property ($rose(rst_n) |->
    fetch_addr == 0 && pc_low_byte == 0) else $error("reset");
  chk_fetch_wrap: assert property (fetch_addr <= M)
    else $error("wrap");
  chk_int_vector: assert property (int_take && !fetch_stall |=>
    fetch_addr == 13'h0004 && fetch_stall) else $error("vector");
  chk_next_step: assert property (go && ctrl.op == PCV_OP_NEXT |=>
    fetch_addr == (($past(fetch_addr) + 1'b1) & M)) else $error("next");
  chk_jump_load: assert property (go && ctrl.op == PCV_OP_GOTO |=>
    fetch_addr == ({$past(pc_upper_write_latch[4:3]),
    $past(ctrl.target)} & M) && fetch_stall) else $error("jump");
  chk_low_load: assert property (sw.low_we && !fetch_stall &&
    !int_take |=> pc_low_byte == $past(sw.wdata)) else $error("low");
  chk_latch_take: assert property (sw.latch_we |=>
    pc_upper_write_latch == $past(sw.wdata[4:0])) else $error("latch");
  chk_stall_once: assert property (fetch_stall |=> !fetch_stall)
    else $error("stall");
endmodule : pcv_core_chk
bind pcv_core pcv_core_chk #(.MEM_WORDS(MEM_WORDS)) i_pcv_core_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .ctrl(ctrl), .int_take(int_take),
  .sw(sw), .fetch_addr(fetch_addr), .pc_low_byte(pc_low_byte),
  .pc_upper_write_latch(pc_upper_write_latch), .fetch_stall(fetch_stall));
`default_nettype wire

// ==== sim/pcv_prog_mem.sv ====
// Program memory array model.
// Assumes fetch_addr stays within the backed words.
`timescale 1ns/1ns
`default_nettype none
module pcv_prog_mem
  import pcv_pkg::*;
#(parameter int MEM_WORDS = 1024)
(
  // Fetch side
  input wire pcv_addr_t fetch_addr,
  output logic [13:0] word
);
  logic [13:0] mem [MEM_WORDS];
  // Each word tags its own address; reads past the end give unknowns
  initial for (int i = 0; i < MEM_WORDS; i++) mem[i] = 14'h2000 | 14'(i);
  assign word = mem[fetch_addr];
endmodule : pcv_prog_mem
`default_nettype wire

// ==== sim/test_program_counter_vectoring.sv ====
// Testbench of pcv_core with the program memory model.
// Assumes the checker binds itself.
`timescale 1ns/1ns
`default_nettype none
module test_program_counter_vectoring;
  import pcv_pkg::*;
  logic ref_clk = 0, rst_n = 0, int_take = 0, stall;
  pcv_ctrl_s ctrl = '{PCV_OP_HOLD, 11'h000};
  pcv_sw_s sw = '0;
  pcv_addr_t fetch_addr;
  pcv_addr_t fetch_big;
  logic [7:0] low;
  logic [4:0] latch;
  logic [13:0] word;
  int fail_count = 0, checks = 0;
  pcv_core i_pcv_core (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl(ctrl),
    .int_take(int_take), .sw(sw), .fetch_addr(fetch_addr),
    .pc_low_byte(low), .pc_upper_write_latch(latch), .fetch_stall(stall));
  pcv_prog_mem i_pcv_prog_mem (.fetch_addr(fetch_addr), .word(word));
  // Larger array variant, driven in step with the small one
  if (1)
  begin : g_large
    pcv_core #(.MEM_WORDS(2048)) i_pcv_core (.ref_clk(ref_clk),
      .rst_n(rst_n), .ctrl(ctrl), .int_take(int_take), .sw(sw),
      .fetch_addr(fetch_big), .pc_low_byte(), .pc_upper_write_latch(),
      .fetch_stall());
  end
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(string n, logic [13:0] s, logic [13:0] x);
    checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  // HOLD follows so the counter stays still once the stall cycle ends
  task automatic go(pcv_op_e o, logic [10:0] t);
    ctrl = '{o, t};
    tick();
    chk("stall", stall, 1);
    ctrl.op = PCV_OP_HOLD;
    tick();
    chk("stall_end", stall, 0);
  endtask : go
  task t_reset();
    rst_n = 0;
    repeat (5) tick();
    rst_n = 1;
    chk("fetch", fetch_addr, 0);
    chk("low", low, 0);
    chk("latch", latch, 0);
    chk("stall_rst", stall, 0);
    chk("big_rst", fetch_big, 0);
  endtask : t_reset
  task automatic t_stack();
    for (int i = 0; i < 8; i++)
    begin
      go(PCV_OP_CALL, 11'(16 * i + 16));
      chk("call", fetch_addr, 14'(16 * i + 16));
    end
    for (int i = 7; i >= 0; i--)
    begin
      go(PCV_OP_RETURN, 11'h000);
      chk("ret", fetch_addr, 14'(16 * i + 1));
    end
  endtask : t_stack
  task t_int();
    int_take = 1;
    tick();
    int_take = 0;
    chk("vector", fetch_addr, 14'h0004);
    tick();
    go(PCV_OP_RETURN, 11'h000);
    chk("iret", fetch_addr, 14'h0001);
  endtask : t_int
  task t_wrap();
    sw = '{1'b0, 1'b1, 8'h1f};
    tick();
    sw = '0;
    chk("latch", latch, 14'h001f);
    go(PCV_OP_GOTO, 11'h7fe);
    chk("goto", fetch_addr, 14'h03fe);
    chk("word", word, 14'h23fe);
    chk("big_goto", fetch_big, 14'h07fe);
    ctrl.op = PCV_OP_NEXT;
    tick();
    chk("next", fetch_addr, 14'h03ff);
    chk("big_next", fetch_big, 14'h07ff);
    tick();
    ctrl.op = PCV_OP_HOLD;
    chk("wrap", fetch_addr, 0);
    chk("big_wrap", fetch_big, 0);
    sw = '{1'b1, 1'b0, 8'h55};
    tick();
    sw = '0;
    chk("low", low, 14'h0055);
    chk("jump", fetch_addr, 14'h0355);
    chk("big_jump", fetch_big, 14'h0755);
    tick();
  endtask : t_wrap
  task end_sim();
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial
  begin
    t_reset();
    t_stack();
    t_int();
    t_wrap();
    t_reset();
    end_sim();
  end
endmodule : test_program_counter_vectoring
`default_nettype wire
